//--- pctls_top.sv
/*
 * PWM combination trigger, combinatorial logic source selection and
 * per-generator status, reached over Avalon-MM with waitrequest.
 * Assumes the eight generators run on i_ref_clk and drive their
 * trigger, output and status signals as plain same-clock levels.
 */
// The Avalon-MM interface to the registers and the register offsets were decided locally.
// Overview of operation
// - Each logic instance picks two sources by 4-bit codes, odd codes low.
// - A code naming an absent generator channel feeds logic zero.
// - Capture flag sets once the time base is latched.
// - Writing one requests a capture; flag blocks captures until cleared.
// - Pending update reads one and blocks user data register writes.
// - Writing update-request sets pending; the request bit reads zero.
// - Steering bit reads one in second push-pull cycle.
// - Half bit reads one in second half of a center-aligned cycle.
// - Trigger bit reads one while a PWM cycle is in progress.
`timescale 1ns/1ps
module pctls_top
   import pctls_pkg::*;
#(
   parameter int         LOGIC_COUNT = 6,
   parameter logic [7:0] GEN_PRESENT = 8'hFF
)
(
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_srst,
   input  wire logic [pctls_pkg::ADDR_W-1:0] i_avs_address,
   input  wire logic                         i_avs_read,
   input  wire logic                         i_avs_write,
   input  wire logic [pctls_pkg::DATA_W-1:0] i_avs_writedata,
   input  wire logic [3:0]                   i_avs_byteenable,
   output logic      [pctls_pkg::DATA_W-1:0] o_avs_readdata,
   output logic                              o_avs_waitrequest,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_cycle_active_flag_out,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_high_out,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_low_out,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_capture_event,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_update_done,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_pushpull_phase,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_center_half,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_gen_cycle_active,
   output logic                              o_combo_cycle_active_flag_a,
   output logic      [LOGIC_COUNT-1:0]       o_logic_src_one,
   output logic      [LOGIC_COUNT-1:0]       o_logic_src_two,
   output logic      [pctls_pkg::NUM_GEN-1:0] o_sw_capture_req,
   output logic      [pctls_pkg::NUM_GEN-1:0] o_capture_allow,
   output logic      [pctls_pkg::NUM_GEN-1:0] o_data_refresh_req,
   output logic      [pctls_pkg::NUM_GEN-1:0] o_data_write_block
);
   import pctls_pkg::*;

   // ************************************************************
   // Types and storage
   // ************************************************************
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } pctls_bus_state_type;

   pctls_bus_state_type bus_state_reg;
   pctls_bus_state_type bus_state_next;

   logic [15:0]        combo_trigger_low_enables_reg;
   logic [15:0]        combo_logic_control_y_reg [LOGIC_COUNT];
   logic [NUM_GEN-1:0] cap_reg;
   logic [NUM_GEN-1:0] cap_next;
   logic [NUM_GEN-1:0] pend_reg;
   logic [NUM_GEN-1:0] pend_next;
   logic [NUM_GEN-1:0] pushpull_phase_flag_reg;
   logic [NUM_GEN-1:0] center_half_flag_reg;
   logic [NUM_GEN-1:0] cycle_active_flag_reg;

   logic               commit_wr;
   logic               is_combo;
   logic               is_logic;
   logic               is_status;
   logic [7:0]         rel_logic;
   logic [7:0]         rel_status;
   logic [2:0]         logic_idx;
   logic [2:0]         status_idx;
   logic [NUM_GEN-1:0] stat_wr;
   logic [NUM_GEN-1:0] cap_req_wr;
   logic [NUM_GEN-1:0] cap_clr_wr;
   logic [NUM_GEN-1:0] refresh_wr;
   logic [NUM_GEN-1:0] cycle_active_flag_masked;
   logic               cycle_active_flag_any;
   logic [31:0]        rd_mux;

   // ************************************************************
   // Address decode
   // ************************************************************
   // Unmapped words read zero and swallow writes, so software probing
   // the map never hangs the bus.
   always_comb
   begin
      rel_logic  = i_avs_address - OFS_LOGIC_BASE;
      rel_status = i_avs_address - OFS_STATUS_BASE;
      logic_idx  = rel_logic[4:2];
      status_idx = rel_status[4:2];
      is_combo   = (i_avs_address == OFS_COMBO_CYCLE_ACTIVE_FLAG);
      is_logic   = (i_avs_address[1:0] == 2'h0) &&
                   (i_avs_address >= OFS_LOGIC_BASE) &&
                   (rel_logic[7:2] < 6'(LOGIC_COUNT));
      is_status  = (i_avs_address[1:0] == 2'h0) &&
                   (i_avs_address >= OFS_STATUS_BASE) &&
                   (rel_status[7:2] < 6'(NUM_GEN));
   end

   // ************************************************************
   // Bus handshake
   // ************************************************************
   // Every access takes one wait cycle; read data is captured on
   // entry to the acknowledge cycle and stands while waitrequest is low.
   always_comb
   begin
      case (bus_state_reg)
         BUS_IDLE:
         begin
            bus_state_next = (i_avs_read || i_avs_write) ? BUS_ACK
                                                         : BUS_IDLE;
         end
         BUS_ACK:
         begin
            bus_state_next = BUS_IDLE;
         end
         default:
         begin
            bus_state_next = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         bus_state_reg     <= BUS_IDLE;
         o_avs_waitrequest <= 1'b1;
      end
      else
      begin
         bus_state_reg     <= bus_state_next;
         o_avs_waitrequest <= (bus_state_next != BUS_ACK);
      end
   end

   assign commit_wr = (bus_state_reg == BUS_ACK) && i_avs_write;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (is_combo)
      begin
         rd_mux[15:0] = combo_trigger_low_enables_reg;
      end
      else if (is_logic)
      begin
         rd_mux[15:0] = combo_logic_control_y_reg[logic_idx];
      end
      else if (is_status)
      begin
         rd_mux[STAT_CAP_BIT]   = cap_reg[status_idx];
         rd_mux[STAT_UPD_BIT]   = pend_reg[status_idx];
         rd_mux[STAT_REQ_BIT]   = 1'b0;
         rd_mux[STAT_PUSHPULL_PHASE_FLAG_BIT] = pushpull_phase_flag_reg[status_idx];
         rd_mux[STAT_HALF_BIT]  = center_half_flag_reg[status_idx];
         rd_mux[STAT_CYCLE_ACTIVE_FLAG_BIT]  = cycle_active_flag_reg[status_idx];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_avs_readdata <= 32'h0000_0000;
      end
      else if (bus_state_reg == BUS_IDLE && i_avs_read)
      begin
         o_avs_readdata <= rd_mux;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         combo_trigger_low_enables_reg <= COMBO_RESET;
      end
      else if (commit_wr && is_combo)
      begin
         combo_trigger_low_enables_reg <= merge_write(
            combo_trigger_low_enables_reg, i_avs_writedata,
            i_avs_byteenable, COMBO_MASK);
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         for (int y = 0; y < LOGIC_COUNT; y++)
         begin
            combo_logic_control_y_reg[y] <= LOGIC_RESET;
         end
      end
      else if (commit_wr && is_logic)
      begin
         combo_logic_control_y_reg[logic_idx] <= merge_write(
            combo_logic_control_y_reg[logic_idx], i_avs_writedata,
            i_avs_byteenable, LOGIC_MASK);
      end
   end

   // ************************************************************
   // Combination trigger A
   // ************************************************************
   assign cycle_active_flag_masked = i_gen_cycle_active_flag_out &
                        combo_trigger_low_enables_reg[NUM_GEN-1:0];
   assign cycle_active_flag_any    = |cycle_active_flag_masked;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_combo_cycle_active_flag_a <= 1'b0;
      end
      else
      begin
         o_combo_cycle_active_flag_a <= cycle_active_flag_any;
      end
   end

   // ************************************************************
   // Logic source instances
   // ************************************************************
   for (genvar y = 0; y < LOGIC_COUNT; y++)
   begin : g_cell
      pctls_logic_cell #(
         .GEN_PRESENT (GEN_PRESENT)
      ) u_cell (
         .i_ref_clk  (i_ref_clk),
         .i_srst     (i_srst),
         .i_high_out (i_gen_high_out),
         .i_low_out  (i_gen_low_out),
         .i_sel_one  (combo_logic_control_y_reg[y][LOG_SRC1_LSB +: SEL_W]),
         .i_sel_two  (combo_logic_control_y_reg[y][LOG_SRC2_LSB +: SEL_W]),
         .i_inv_one  (combo_logic_control_y_reg[y][LOG_INV1_BIT]),
         .i_inv_two  (combo_logic_control_y_reg[y][LOG_INV2_BIT]),
         .o_src_one  (o_logic_src_one[y]),
         .o_src_two  (o_logic_src_two[y])
      );
   end

   // ************************************************************
   // Generator status
   // ************************************************************
   // A hardware set wins over a software clear in the same cycle only while the flag is clear; once it is set, the clear wins.
   always_comb
   begin
      for (int g = 0; g < NUM_GEN; g++)
      begin
         stat_wr[g]    = commit_wr && is_status && (status_idx == 3'(g)) &&
                         i_avs_byteenable[0];
         cap_req_wr[g] = stat_wr[g] && i_avs_writedata[STAT_CAP_BIT];
         cap_clr_wr[g] = stat_wr[g] && !i_avs_writedata[STAT_CAP_BIT];
         refresh_wr[g] = stat_wr[g] && i_avs_writedata[STAT_REQ_BIT];
         cap_next[g]   = cap_reg[g];
         if (i_gen_capture_event[g] && !cap_reg[g])
         begin
            cap_next[g] = 1'b1;
         end
         else if (cap_clr_wr[g])
         begin
            cap_next[g] = 1'b0;
         end
         pend_next[g] = pend_reg[g];
         if (refresh_wr[g])
         begin
            pend_next[g] = 1'b1;
         end
         else if (i_gen_update_done[g])
         begin
            pend_next[g] = 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         cap_reg          <= '0;
         o_capture_allow  <= '1;
         o_sw_capture_req <= '0;
      end
      else
      begin
         cap_reg          <= cap_next;
         o_capture_allow  <= ~cap_next;
         o_sw_capture_req <= cap_req_wr & ~cap_reg;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         pend_reg           <= '0;
         o_data_write_block <= '0;
         o_data_refresh_req <= '0;
      end
      else
      begin
         pend_reg           <= pend_next;
         o_data_write_block <= pend_next;
         o_data_refresh_req <= refresh_wr;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         pushpull_phase_flag_reg <= '0;
         center_half_flag_reg    <= '0;
         cycle_active_flag_reg   <= '0;
      end
      else
      begin
         pushpull_phase_flag_reg <= i_gen_pushpull_phase;
         center_half_flag_reg    <= i_gen_center_half;
         cycle_active_flag_reg   <= i_gen_cycle_active;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   a_combo_cycle_active_flag_or: assert property (
      ##1 o_combo_cycle_active_flag_a == $past(|(i_gen_cycle_active_flag_out &
                                    combo_trigger_low_enables_reg[7:0])))
      else $error("trigger A is not the enabled OR");

   a_capture_sets: assert property (
      (i_gen_capture_event[0] && !cap_reg[0])
      |=> cap_reg[0] && !o_capture_allow[0])
      else $error("capture flag not set by capture");

   a_capture_hold: assert property (
      (cap_reg[0] && !cap_clr_wr[0])
      |=> cap_reg[0] && !o_sw_capture_req[0])
      else $error("capture flag dropped or capture repeated");

   a_pending_blocks: assert property (
      pend_reg[1] |-> o_data_write_block[1])
      else $error("pending update does not block writes");

   a_refresh_pending: assert property (
      refresh_wr[1] |=> pend_reg[1] && o_data_refresh_req[1]
      ##1 !o_data_refresh_req[1] || refresh_wr[1])
      else $error("refresh request did not set pending");

   a_request_reads_zero: assert property (
      (bus_state_reg == BUS_ACK && i_avs_read && is_status)
      |-> !o_avs_readdata[3])
      else $error("update request bit read as one");

   a_pushpull_phase_flag_tracks: assert property (
      ##1 pushpull_phase_flag_reg[2] == $past(i_gen_pushpull_phase[2]))
      else $error("steering flag does not follow phase");

   a_half_tracks: assert property (
      ##1 center_half_flag_reg[3] == $past(i_gen_center_half[3]))
      else $error("half flag does not follow time base");

   a_cycle_active_flag_tracks: assert property (
      ##1 cycle_active_flag_reg[4] == $past(i_gen_cycle_active[4]))
      else $error("cycle flag does not follow generator");

   a_bus_one_wait: assert property (
      (bus_state_reg == BUS_IDLE && (i_avs_read || i_avs_write))
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not one cycle after request");

   c_combo_cycle_active_flag: cover property (cycle_active_flag_any ##1 o_combo_cycle_active_flag_a);
   c_capture: cover property (cap_req_wr[0] ##1 o_sw_capture_req[0]);
   c_refresh: cover property (refresh_wr[1] ##[1:20] !pend_reg[1]);
   c_status_read: cover property (
      bus_state_reg == BUS_ACK && i_avs_read && is_status);

endmodule : pctls_top

//--- pctls_pkg.sv
/*
 * Package for the PWM combiner, logic-source and status block: register
 * offsets, field positions, reset values and shared functions.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package pctls_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NUM_GEN   = 8;
   localparam int NUM_LOGIC = 6;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int REG_W     = 16;
   localparam int SEL_W     = 4;

   // ************************************************************
   // Register offsets (byte addresses, one word per register)
   // ************************************************************
   localparam logic [7:0] OFS_COMBO_CYCLE_ACTIVE_FLAG  = 8'h00;
   localparam logic [7:0] OFS_LOGIC_BASE  = 8'h04;
   localparam logic [7:0] OFS_STATUS_BASE = 8'h20;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LOG_SRC1_LSB = 12;
   localparam int LOG_SRC2_LSB = 8;
   localparam int LOG_INV1_BIT = 7;
   localparam int LOG_INV2_BIT = 6;
   localparam int STAT_CAP_BIT   = 5;
   localparam int STAT_UPD_BIT   = 4;
   localparam int STAT_REQ_BIT   = 3;
   localparam int STAT_PUSHPULL_PHASE_FLAG_BIT = 2;
   localparam int STAT_HALF_BIT  = 1;
   localparam int STAT_CYCLE_ACTIVE_FLAG_BIT  = 0;

   // ************************************************************
   // Reset values and writable masks
   // ************************************************************
   localparam logic [15:0] COMBO_RESET = 16'h0000;
   localparam logic [15:0] COMBO_MASK  = 16'h00FF;
   localparam logic [15:0] LOGIC_RESET = 16'h0000;
   localparam logic [15:0] LOGIC_MASK  = 16'hFFF7;
   localparam logic [7:0]  GEN_PRESENT_ALL = 8'hFF;

   // ************************************************************
   // Shared functions
   // ************************************************************
   // Byte-lane merge of a 16-bit register, masked to its writable bits
   function automatic logic [15:0] merge_write(
      input logic [15:0] old_val,
      input logic [31:0] wdata,
      input logic [3:0]  be,
      input logic [15:0] mask);
      logic [15:0] res;
      res = old_val;
      if (be[0])
      begin
         res[7:0] = wdata[7:0];
      end
      if (be[1])
      begin
         res[15:8] = wdata[15:8];
      end
      return res & mask;
   endfunction : merge_write

   // Even codes pick a high output, odd codes a low output
   function automatic logic pick_source(
      input logic [15:0] sigs,
      input logic [3:0]  code);
      return sigs[code];
   endfunction : pick_source

endpackage : pctls_pkg

//--- pctls_logic_cell.sv
/*
 * One combinatorial logic instance: selects two of sixteen PWM outputs
 * and applies per-source polarity. Outputs are registered.
 * Assumes generator outputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module pctls_logic_cell
   import pctls_pkg::*;
#(
   parameter logic [7:0] GEN_PRESENT = 8'hFF
)
(
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_srst,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_high_out,
   input  wire logic [pctls_pkg::NUM_GEN-1:0] i_low_out,
   input  wire logic [pctls_pkg::SEL_W-1:0] i_sel_one,
   input  wire logic [pctls_pkg::SEL_W-1:0] i_sel_two,
   input  wire logic                  i_inv_one,
   input  wire logic                  i_inv_two,
   output logic                       o_src_one,
   output logic                       o_src_two
);
   import pctls_pkg::*;

   logic [15:0] sigs;

   // Absent channels are forced low before selection
   always_comb
   begin
      for (int g = 0; g < NUM_GEN; g++)
      begin
         sigs[2*g]   = i_high_out[g] & GEN_PRESENT[g];
         sigs[2*g+1] = i_low_out[g] & GEN_PRESENT[g];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_src_one <= 1'b0;
         o_src_two <= 1'b0;
      end
      else
      begin
         o_src_one <= pick_source(sigs, i_sel_one) ^ i_inv_one;
         o_src_two <= pick_source(sigs, i_sel_two) ^ i_inv_two;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   logic absent_one;
   assign absent_one = !GEN_PRESENT[i_sel_one[3:1]];

   a_src_gen1_high: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (i_sel_one == 4'h0 && !i_inv_one && GEN_PRESENT[0])
      |=> o_src_one == $past(i_high_out[0]))
      else $error("source one does not follow generator 1 high");
   a_src_absent_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      absent_one |=> o_src_one == $past(i_inv_one))
      else $error("absent channel not tied to zero");
   a_src_invert: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (i_sel_one == i_sel_two && i_inv_one != i_inv_two)
      |=> o_src_one != o_src_two)
      else $error("source polarity not applied");

endmodule : pctls_logic_cell

//--- pctls_gen_model.sv
/* Generator-side model: answers capture and refresh requests.
   Assumes the block's clock and a refresh delay set by the bench. */
`timescale 1ns/1ps
module pctls_gen_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_srst,
   input  wire logic [7:0] i_sw_capture_req,
   input  wire logic [7:0] i_data_refresh_req,
   input  wire logic [7:0] i_ext_capture,
   input  wire logic [3:0] i_refresh_delay,
   output logic      [7:0] o_capture_event,
   output logic      [7:0] o_update_done
);
   logic [7:0] pend_reg;
   logic [3:0] cnt_reg;

   // Capture lands one cycle after a request or a bench event
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_capture_event <= 8'h00;
      else
         o_capture_event <= i_sw_capture_req | i_ext_capture;
   end

   // Slow refresh, so the pending state can be seen from the bus
   always_ff @(posedge i_ref_clk)
   begin
      o_update_done <= 8'h00;
      if (i_srst)
      begin
         pend_reg <= 8'h00;
         cnt_reg  <= 4'h0;
      end
      else if (i_data_refresh_req != 8'h00)
      begin
         pend_reg <= pend_reg | i_data_refresh_req;
         cnt_reg  <= i_refresh_delay;
      end
      else if (cnt_reg == 4'h1)
      begin
         o_update_done <= pend_reg;
         pend_reg      <= 8'h00;
         cnt_reg       <= 4'h0;
      end
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
endmodule : pctls_gen_model

//--- pwm_combo_trigger_logic_status_test.sv
/* Self-checking bench: register and generator-link tests over Avalon-MM.
   Assumes generator 8 is absent, so its sources must read zero. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pwm_combo_trigger_logic_status_test;
   import pctls_pkg::*;
   localparam logic [7:0] PRESENT = 8'h7F;
   logic        ref_clk = 1'b0;
   logic        srst, rd, wr, waitreq, cycle_active_flag_a;
   logic [7:0]  adr, cycle_active_flag, high, low, phase, half, active, ext_cap;
   logic [7:0]  cap_ev, upd_done, cap_req, allow, ref_req, wblock;
   logic [31:0] wdat, rdat;
   logic [5:0]  src1, src2;
   logic [3:0]  dly;
   int          n_errors = 0, checked = 0, cycles = 0, n_cap = 0;

   always #20 ref_clk = ~ref_clk;

   pctls_top #(.LOGIC_COUNT(6), .GEN_PRESENT(PRESENT)) u_dut (
      .i_ref_clk(ref_clk), .i_srst(srst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(4'h3), .o_avs_readdata(rdat),
      .o_avs_waitrequest(waitreq), .i_gen_cycle_active_flag_out(cycle_active_flag),
      .i_gen_high_out(high), .i_gen_low_out(low),
      .i_gen_capture_event(cap_ev), .i_gen_update_done(upd_done),
      .i_gen_pushpull_phase(phase), .i_gen_center_half(half),
      .i_gen_cycle_active(active), .o_combo_cycle_active_flag_a(cycle_active_flag_a),
      .o_logic_src_one(src1), .o_logic_src_two(src2),
      .o_sw_capture_req(cap_req), .o_capture_allow(allow),
      .o_data_refresh_req(ref_req), .o_data_write_block(wblock));

   pctls_gen_model u_gen (
      .i_ref_clk(ref_clk), .i_srst(srst), .i_sw_capture_req(cap_req),
      .i_data_refresh_req(ref_req), .i_ext_capture(ext_cap),
      .i_refresh_delay(dly), .o_capture_event(cap_ev),
      .o_update_done(upd_done));

   // Hang guard, and a count of software capture pulses for gen 1
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cap_req[0] === 1'b1)
         n_cap++;
      if (cycles == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
      @(posedge ref_clk);
      adr  <= a;
      wdat <= {16'h0000, d};
      rd   <= ~w;
      wr   <= w;
      @(posedge ref_clk);
      while (waitreq !== 1'b0) @(posedge ref_clk);
      q = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      `CHK("readback", e, q)
      `CHK("readback_hi", 16'h0000, rdat[31:16])
   endtask : rd_chk

   // Source seen by a logic input: absent channels read zero
   function automatic logic exp_src(input int c);
      logic [7:0] s;
      s = c[0] ? low : high;
      return s[c >> 1] & PRESENT[c >> 1];
   endfunction : exp_src

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      srst = 1'b1;
      {rd, wr, adr, wdat, ext_cap} = '0;
      {cycle_active_flag, high, low, phase, half, active} = '0;
      dly = 4'h8;
      tick(4);
      srst <= 1'b0;
      `CHK("allow_rst", 8'hFF, allow)
      rd_chk(OFS_COMBO_CYCLE_ACTIVE_FLAG, 16'h0000);
      rd_chk(OFS_LOGIC_BASE, 16'h0000);
      rd_chk(OFS_STATUS_BASE, 16'h0000);
      wr_reg(OFS_COMBO_CYCLE_ACTIVE_FLAG, 16'hFFFF);
      rd_chk(OFS_COMBO_CYCLE_ACTIVE_FLAG, 16'h00FF);
      wr_reg(8'h40, 16'hFFFF);
      rd_chk(8'h40, 16'h0000);
      $display("reset and map test done");
      for (int g = 0; g < 8; g++)
      begin
         wr_reg(OFS_COMBO_CYCLE_ACTIVE_FLAG, 16'(1 << g));
         cycle_active_flag <= ~(8'h01 << g);
         tick(2);
         `CHK("cycle_active_flag_off", 1'b0, cycle_active_flag_a)
         cycle_active_flag <= 8'h01 << g;
         tick(2);
         `CHK("cycle_active_flag_on", 1'b1, cycle_active_flag_a)
      end
      $display("trigger test done");
      high <= 8'hA5;
      low  <= 8'h3C;
      for (int y = 0; y < 6; y++)
         for (int c = 0; c < 16; c++)
         begin
            wr_reg(OFS_LOGIC_BASE + 8'(4 * y),
                   {4'(c), 4'(15 - c), c[1], c[2], 6'h00});
            tick(2);
            `CHK("src1", exp_src(c) ^ c[1], src1[y])
            `CHK("src2", exp_src(15 - c) ^ c[2], src2[y])
         end
      rd_chk(8'h18, 16'hF0C0);
      wr_reg(OFS_LOGIC_BASE, 16'h6680);
      tick(2);
      `CHK("inv1", exp_src(6) ^ 1'b1, src1[0])
      `CHK("inv2", exp_src(6), src2[0])
      $display("logic source test done");
      wr_reg(OFS_STATUS_BASE, 16'h0020);
      tick(3);
      rd_chk(OFS_STATUS_BASE, 16'h0020);
      `CHK("allow0", 1'b0, allow[0])
      wr_reg(OFS_STATUS_BASE, 16'h0020);
      tick(3);
      `CHK("cap_pulses", 1, n_cap)
      wr_reg(OFS_STATUS_BASE, 16'h0000);
      tick(2);
      `CHK("allow0", 1'b1, allow[0])
      ext_cap <= 8'h04;
      tick(1);
      ext_cap <= 8'h00;
      tick(3);
      rd_chk(8'h28, 16'h0020);
      wr_reg(8'h28, 16'h0000);
      $display("capture test done");
      wr_reg(8'h24, 16'h0008);
      rd_chk(8'h24, 16'h0010);
      `CHK("wblock", 1'b1, wblock[1])
      tick(12);
      rd_chk(8'h24, 16'h0000);
      `CHK("wblock", 1'b0, wblock[1])
      $display("refresh test done");
      for (int p = 0; p < 2; p++)
      begin
         phase  <= p ? 8'hA5 : 8'h5A;
         half   <= p ? 8'hCC : 8'h33;
         active <= p ? 8'hF0 : 8'h0F;
         tick(2);
         for (int g = 0; g < 8; g++)
            rd_chk(OFS_STATUS_BASE + 8'(4 * g),
                   16'({phase[g], half[g], active[g]}));
      end
      $display("status test done");
      finish_test();
   end
endmodule : pwm_combo_trigger_logic_status_test
